// >>> core/dacseq_params.svh
// register offsets, field positions, reset values and limits of the sequencer
`ifndef DACSEQ_PARAMS_SVH
`define DACSEQ_PARAMS_SVH

// register byte offsets
`define OFS_DAC_CTL    8'h00
`define OFS_FIFO_CTL   8'h04
`define OFS_FIFO_WORDS 8'h08
`define OFS_SEQ_STEP   8'h0c
`define OFS_A_INPUT    8'h10
`define OFS_A_OUTPUT   8'h14
`define OFS_ADC_CTL    8'h18
`define OFS_STATUS     8'h1c
`define OFS_B_INPUT    8'h20
`define OFS_B_OUTPUT   8'h24

// reset values
`define RST_DAC_CTL  8'h00
`define RST_FIFO_CTL 8'h00

// power and reference control fields
`define DC_A_MODE   7:6
`define DC_B_MODE   5:4
`define DC_OA2_BIT  4
`define DC_OA1_BIT  3
`define DC_REF_SEL  2:1
`define DC_INTERNAL_REFERENCE_ENABLE_BIT 0

// waveform control fields
`define FC_EN_BIT  7
`define FC_BIP_BIT 6
`define FC_SYM_BIT 5
`define FC_CON_BIT 4
`define FC_DEPTH   3:0

// storage and data limits
`define FIFO_SLOTS 5'd16
`define WORD_MSB   15
`define WORD_LSB   4
`define CODE_MAX   12'hfff
`define MODE_OFF   2'b00
`define MODE_INPUT 2'b10
`define MODE_SHIFT 2'b11

`endif

// >>> core/dacseq_pkg.sv
// types shared by the waveform sequencer and its bench
package dacseq_pkg;

	// classic wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	// classic wishbone answer from the slave
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	// waveform phases in the order they are walked
	typedef enum logic [1:0] {PH_ADD_UP, PH_ADD_DOWN, PH_SUB_UP, PH_SUB_DOWN} phase_t;

	// analog control levels toward the converter macro
	typedef struct packed {
		logic       a_powered;
		logic       a_drive;
		logic [1:0] a_mode;
		logic       b_powered;
		logic       b_drive;
		logic [1:0] b_mode;
		logic       opamp_one_on;
		logic       opamp_two_on;
		logic [1:0] ref_sel;
		logic       ref_buffer_on;
		logic       int_ref_on;
	} analog_ctl_t;

	// whole state of the sequencer block
	typedef struct packed {
		logic [7:0]        dctl;
		logic [7:0]        fctl;
		logic [11:0]       in_a;
		logic [11:0]       out_a;
		logic [11:0]       in_b;
		logic [11:0]       out_b;
		logic [15:0][11:0] words;
		logic [4:0]        wptr;
		logic [4:0]        rptr;
		logic [4:0]        idx;
		phase_t            phase;
		logic              started;
		logic              done;
		logic              pin_s1;
		logic              pin_s2;
		logic              pin_s3;
		logic              ack;
		logic [31:0]       rdat;
	} seq_state_t;

endpackage

// >>> core/dac_fifo_waveform_sequencer.sv
// dac power control and first-channel fifo waveform sequencer, wishbone slave
//
// Overview of operation
// - reset leaves dacs, op amps off, undriven
// - first dac mode: power and write routing
// - second dac same modes, dual variant only
// - op amp one bit powers op amp one; op amp two bit works in the single variant only
// - reference select picks gain or voltage
// - reference enable mirrored in two registers
// - changed waveform control restarts the sequence
// - enabled: next step copies input to output
// - dac writes leave sequence position alone
// - word writes ignored while sequencing enabled
// - add in phases 1-2, subtract 3-4
// - symmetry and bipolar bits choose which phases run
// - continuous bit repeats, else one pass
// - sixteen words stored, depth field limits use
// - first output input value, then locations
// - word is 12 bits, left justified
// - word access starts at location one
// - no overwrite past end, reads zero
// - unsigned or sign-magnitude word per bipolar
// - sequence register write or pin steps
// - depth equals code plus one
`timescale 1ns/100ps
`default_nettype none
`include "dacseq_params.svh"

module dac_fifo_waveform_sequencer #(
	parameter bit DUAL_DAC = 1'b1
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  SYS_RST,
	input  wire dacseq_pkg::wb_req_t   WB_REQ,
	output var  dacseq_pkg::wb_rsp_t   WB_RSP,
	input  wire logic                  PIN_LOAD_FIRST_DAC,
	output logic [11:0]                FIRST_DAC_CODE,
	output logic [11:0]                SECOND_DAC_CODE,
	output var  dacseq_pkg::analog_ctl_t ANALOG_CTL
);
	import dacseq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// elaboration check

	// five-bit pointers and the sixteen-entry word array assume sixteen slots
	if (`FIFO_SLOTS != 5'd16) begin : g_slot_check
		$error("word store must hold sixteen locations");
	end

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane merge of a bus write into the old register image
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		// unselected lanes keep their old bits, so partial writes are safe
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// write routing of one dac by its power mode, result is {input, output}
	function automatic logic [23:0] mode_write(
		input logic [1:0]  mode,
		input logic [11:0] in_v,
		input logic [11:0] out_v,
		input logic [11:0] d
	);
		// mode 11 moves the old input to the output as the new input lands
		case (mode)
			`MODE_INPUT: return {d, out_v};
			`MODE_SHIFT: return {d, in_v};
			default:     return {d, d};
		endcase
	endfunction

	// input value plus or minus one stored word, clamped
	function automatic logic [11:0] combine(
		input logic [11:0] in_v,
		input logic [11:0] w,
		input logic        neg,
		input logic        bip
	);
		logic signed [13:0] v;
		logic signed [13:0] s;
		v = '0;
		s = '0;
		if (bip) begin
			v = $signed({3'b000, w[10:0]});
			if (w[11]) begin
				v = -v;
			end
		end else begin
			v = $signed({2'b00, w});
		end
		if (neg) begin
			v = -v;
		end
		// fourteen signed bits hold any sum or difference, nothing wraps before the clamp
		s = $signed({2'b00, in_v}) + v;
		if (s < 0) begin
			return 12'h000;
		end else if (s > $signed({2'b00, `CODE_MAX})) begin
			return `CODE_MAX;
		end else begin
			return s[11:0];
		end
	endfunction

	// phase after p, top bit set when the waveform pass is over
	function automatic logic [2:0] next_phase(
		input phase_t p,
		input logic   bip,
		input logic   sym
	);
		// asymmetric unipolar has only its up phase, so it always ends the pass
		case ({bip, sym})
			2'b01: return (p == PH_ADD_UP) ? {1'b0, PH_ADD_DOWN} : 3'b100;
			2'b10: return (p == PH_ADD_UP) ? {1'b0, PH_SUB_DOWN} : 3'b100;
			2'b11: return (p == PH_SUB_DOWN) ? 3'b100 : {1'b0, p + 2'd1};
			default: return 3'b100;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	seq_state_t s_r;
	seq_state_t s_nxt;

	logic        req;
	logic        go;
	logic        seq_wr;
	logic        pin_rise;
	logic [4:0]  depth;
	logic [31:0] merged;
	logic [2:0]  np;
	logic [23:0] io;
	logic [4:0]  ix;
	logic [4:0]  slot;
	phase_t      ph;

	////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		s_nxt    = s_r;
		ph       = s_r.phase;
		ix       = s_r.idx;
		np       = '0;
		io       = '0;
		slot     = '0;
		// pin crosses in through two flops, third flop only for the edge
		// the pin is asynchronous, so nothing but the second flop reads the first
		s_nxt.pin_s1 = PIN_LOAD_FIRST_DAC;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.pin_s3 = s_r.pin_s2;
		pin_rise = s_r.pin_s2 & ~s_r.pin_s3;

		// one-cycle ack, a held request is not served twice
		req      = WB_REQ.cyc & WB_REQ.stb & ~s_r.ack;
		s_nxt.ack  = req;
		s_nxt.rdat = '0;
		merged   = lane_merge(32'h0, WB_REQ.dat, WB_REQ.sel);
		seq_wr   = req & WB_REQ.we & (WB_REQ.adr == `OFS_SEQ_STEP);
		go       = (seq_wr | pin_rise) & s_r.fctl[`FC_EN_BIT];
		depth    = {1'b0, s_r.fctl[`FC_DEPTH]} + 5'd1;

		// sequence stepping
		// a single pass that has ended ignores steps until the control changes
		if (go && !s_r.done) begin
			if (!s_r.started) begin
				s_nxt.out_a   = s_r.in_a;
				s_nxt.started = 1'b1;
				s_nxt.phase   = PH_ADD_UP;
				s_nxt.idx     = 5'd0;
			end else begin
				np = 3'b000;
				if (ph == PH_ADD_UP || ph == PH_SUB_UP) begin
					if (ix < depth) begin
						ix = ix + 5'd1;
					end else begin
						np = next_phase(ph, s_r.fctl[`FC_BIP_BIT], s_r.fctl[`FC_SYM_BIT]);
					end
				end else begin
					if (ix > 5'd1) begin
						ix = ix - 5'd1;
					end else begin
						np = next_phase(ph, s_r.fctl[`FC_BIP_BIT], s_r.fctl[`FC_SYM_BIT]);
					end
				end
				// leaving an up phase at depth repeats the deepest word once going down
				if (np[2]) begin
					// pass finished: repeat from the bare input value or stop
					if (s_r.fctl[`FC_CON_BIT]) begin
						s_nxt.out_a = s_r.in_a;
						s_nxt.phase = PH_ADD_UP;
						s_nxt.idx   = 5'd0;
					end else begin
						s_nxt.done = 1'b1;
					end
				end else begin
					if (np != 3'b000 || ph != s_r.phase) begin
						ph = phase_t'(np[1:0]);
						// up phases restart at location one, down ones at depth
						ix = (ph == PH_ADD_UP || ph == PH_SUB_UP) ? 5'd1 : depth;
					end
					slot = ix - 5'd1;
					s_nxt.phase = ph;
					s_nxt.idx   = ix;
					s_nxt.out_a = combine(s_r.in_a, s_r.words[slot[3:0]],
						ph == PH_SUB_UP || ph == PH_SUB_DOWN,
						s_r.fctl[`FC_BIP_BIT]);
				end
			end
		end

		// bus access; any other register rewinds the word pointers
		// state changes at the request edge, the same edge that raises ack
		if (req) begin
			if (WB_REQ.adr != `OFS_FIFO_WORDS) begin
				s_nxt.wptr = 5'd0;
				s_nxt.rptr = 5'd0;
			end
			if (WB_REQ.we) begin
				case (WB_REQ.adr)
					`OFS_DAC_CTL: begin
						merged = lane_merge({24'h0, s_r.dctl}, WB_REQ.dat, WB_REQ.sel);
						s_nxt.dctl = merged[7:0];
					end
					`OFS_ADC_CTL: begin
						merged = lane_merge({31'h0, s_r.dctl[`DC_INTERNAL_REFERENCE_ENABLE_BIT]},
							WB_REQ.dat, WB_REQ.sel);
						s_nxt.dctl[`DC_INTERNAL_REFERENCE_ENABLE_BIT] = merged[0];
					end
					`OFS_FIFO_CTL: begin
						merged = lane_merge({24'h0, s_r.fctl}, WB_REQ.dat, WB_REQ.sel);
						if (merged[7:0] != s_r.fctl) begin
							// a changed setting restarts, even over a pin step
							s_nxt.fctl    = merged[7:0];
							s_nxt.started = 1'b0;
							s_nxt.done    = 1'b0;
							s_nxt.idx     = 5'd0;
							s_nxt.phase   = PH_ADD_UP;
						end
					end
					`OFS_FIFO_WORDS: begin
						merged = lane_merge({16'h0, s_r.words[s_r.wptr[3:0]], 4'h0},
							WB_REQ.dat, WB_REQ.sel);
						if (!s_r.fctl[`FC_EN_BIT] && s_r.wptr < `FIFO_SLOTS) begin
							s_nxt.words[s_r.wptr[3:0]] = merged[`WORD_MSB:`WORD_LSB];
							s_nxt.wptr = s_r.wptr + 5'd1;
						end
					end
					`OFS_A_INPUT: begin
						merged = lane_merge({20'h0, s_r.in_a}, WB_REQ.dat, WB_REQ.sel);
						io = mode_write(s_r.dctl[`DC_A_MODE], s_r.in_a, s_r.out_a,
							merged[11:0]);
						s_nxt.in_a = io[23:12];
						// keep a step's output unless this write routes to output
						if (s_r.dctl[`DC_A_MODE] != `MODE_INPUT) begin
							s_nxt.out_a = io[11:0];
						end
					end
					`OFS_A_OUTPUT: begin
						merged = lane_merge({20'h0, s_r.out_a}, WB_REQ.dat, WB_REQ.sel);
						s_nxt.out_a = merged[11:0];
					end
					`OFS_B_INPUT: begin
						if (DUAL_DAC) begin
							merged = lane_merge({20'h0, s_r.in_b}, WB_REQ.dat, WB_REQ.sel);
							io = mode_write(s_r.dctl[`DC_B_MODE], s_r.in_b, s_r.out_b,
								merged[11:0]);
							s_nxt.in_b  = io[23:12];
							s_nxt.out_b = io[11:0];
						end
					end
					`OFS_B_OUTPUT: begin
						if (DUAL_DAC) begin
							merged = lane_merge({20'h0, s_r.out_b}, WB_REQ.dat, WB_REQ.sel);
							s_nxt.out_b = merged[11:0];
						end
					end
					default: begin
						// step register and unmapped offsets store nothing
						s_nxt.rdat = 32'h0;
					end
				endcase
			end else begin
				case (WB_REQ.adr)
					`OFS_DAC_CTL:  s_nxt.rdat = {24'h0, s_r.dctl};
					`OFS_ADC_CTL:  s_nxt.rdat = {31'h0, s_r.dctl[`DC_INTERNAL_REFERENCE_ENABLE_BIT]};
					`OFS_FIFO_CTL: s_nxt.rdat = {24'h0, s_r.fctl};
					`OFS_FIFO_WORDS: begin
						// reads allowed at any time, past the end they give zero
						if (s_r.rptr < `FIFO_SLOTS) begin
							s_nxt.rdat = {16'h0, s_r.words[s_r.rptr[3:0]], 4'h0};
							s_nxt.rptr = s_r.rptr + 5'd1;
						end else begin
							s_nxt.rdat = 32'h0;
						end
					end
					`OFS_A_INPUT:  s_nxt.rdat = {20'h0, s_r.in_a};
					`OFS_A_OUTPUT: s_nxt.rdat = {20'h0, s_r.out_a};
					`OFS_STATUS: begin
						s_nxt.rdat = {11'h0, s_r.rptr, s_r.wptr, 2'b00, s_r.phase,
							s_r.idx, s_r.done, s_r.started};
					end
					`OFS_B_INPUT:  s_nxt.rdat = DUAL_DAC ? {20'h0, s_r.in_b} : 32'h0;
					`OFS_B_OUTPUT: s_nxt.rdat = DUAL_DAC ? {20'h0, s_r.out_b} : 32'h0;
					default:       s_nxt.rdat = 32'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register, everything off after reset
	// only constants under reset, so a release leaves no half-loaded state

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_r      <= '0;
			s_r.dctl <= `RST_DAC_CTL;
			s_r.fctl <= `RST_FIFO_CTL;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// bus answer straight from flops
	assign WB_RSP.ack = s_r.ack;
	assign WB_RSP.dat = s_r.rdat;

	// converter codes from the output registers
	assign FIRST_DAC_CODE  = s_r.out_a;
	// a single-converter build drives zero on the second code
	assign SECOND_DAC_CODE = DUAL_DAC ? s_r.out_b : 12'h000;

	// power and drive: an unpowered stage floats its output
	always_comb begin
		ANALOG_CTL = '0;
		ANALOG_CTL.a_mode    = s_r.dctl[`DC_A_MODE];
		ANALOG_CTL.a_powered = s_r.dctl[`DC_A_MODE] != `MODE_OFF;
		ANALOG_CTL.a_drive   = ANALOG_CTL.a_powered;
		if (DUAL_DAC) begin
			ANALOG_CTL.b_mode    = s_r.dctl[`DC_B_MODE];
			ANALOG_CTL.b_powered = s_r.dctl[`DC_B_MODE] != `MODE_OFF;
			ANALOG_CTL.b_drive   = ANALOG_CTL.b_powered;
		end else begin
			ANALOG_CTL.opamp_two_on = s_r.dctl[`DC_OA2_BIT];
		end
		ANALOG_CTL.opamp_one_on  = s_r.dctl[`DC_OA1_BIT];
		ANALOG_CTL.ref_sel       = s_r.dctl[`DC_REF_SEL];
		// code 00 leaves the reference buffer off in either reference mode
		ANALOG_CTL.ref_buffer_on = s_r.dctl[`DC_REF_SEL] != 2'b00;
		ANALOG_CTL.int_ref_on    = s_r.dctl[`DC_INTERNAL_REFERENCE_ENABLE_BIT];
	end

endmodule // dac_fifo_waveform_sequencer
`default_nettype wire

// >>> tb/dac_fifo_waveform_sequencer_chk.sv
// port assertions of the waveform sequencer
`timescale 1ns/100ps
`default_nettype none
`include "dacseq_params.svh"
module dac_fifo_waveform_sequencer_chk #(
	parameter bit DUAL_DAC = 1'b1
) (
	input wire logic                    CORE_CLK,
	input wire logic                    SYS_RST,
	input wire dacseq_pkg::wb_req_t     WB_REQ,
	input wire dacseq_pkg::wb_rsp_t     WB_RSP,
	input wire logic                    PIN_LOAD_FIRST_DAC,
	input wire logic [11:0]             FIRST_DAC_CODE,
	input wire logic [11:0]             SECOND_DAC_CODE,
	input wire dacseq_pkg::analog_ctl_t ANALOG_CTL
);
	import dacseq_pkg::*;
	logic taken;
	logic wr0;
	// a request is taken on the edge before its ack
	assign taken = WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
	assign wr0 = taken && WB_REQ.we && WB_REQ.adr == `OFS_DAC_CTL && WB_REQ.sel[0];
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////////////////////////////////////
	property p_rst_off; $fell(SYS_RST) |-> ANALOG_CTL == '0; endproperty
	a_rst_off: assert property (p_rst_off) else $error("controls live after reset");
	property p_ack; taken |=> WB_RSP.ack ##1 !WB_RSP.ack; endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse");
	property p_amode; wr0 |=> ANALOG_CTL.a_mode == $past(WB_REQ.dat[7:6])
		&& ANALOG_CTL.a_powered == ($past(WB_REQ.dat[7:6]) != 2'b00); endproperty
	a_amode: assert property (p_amode) else $error("first dac mode wrong");
	property p_bmode; wr0 && DUAL_DAC |=> ANALOG_CTL.b_mode == $past(WB_REQ.dat[5:4]); endproperty
	a_bmode: assert property (p_bmode) else $error("second dac mode wrong");
	property p_opamp; wr0 |=> ANALOG_CTL.opamp_one_on == $past(WB_REQ.dat[3]); endproperty
	a_opamp: assert property (p_opamp) else $error("op amp enable wrong");
	property p_ref; wr0 |=> ANALOG_CTL.ref_sel == $past(WB_REQ.dat[2:1])
		&& ANALOG_CTL.ref_buffer_on == ($past(WB_REQ.dat[2:1]) != 2'b00); endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");
	property p_mirror; taken && WB_REQ.we && WB_REQ.adr == `OFS_ADC_CTL && WB_REQ.sel[0]
		|=> ANALOG_CTL.int_ref_on == $past(WB_REQ.dat[0]); endproperty
	a_mirror: assert property (p_mirror) else $error("reference mirror lost");
	// the code moves only after a bus write or a pin pulse
	property p_cause; $changed(FIRST_DAC_CODE) |-> $past(taken && WB_REQ.we)
		|| $past(PIN_LOAD_FIRST_DAC, 3) || $past(PIN_LOAD_FIRST_DAC, 4)
		|| $past(PIN_LOAD_FIRST_DAC, 5); endproperty
	a_cause: assert property (p_cause) else $error("code moved without cause");
	c_write: cover property (wr0);
	c_pin: cover property ($rose(PIN_LOAD_FIRST_DAC));
	c_code: cover property ($changed(FIRST_DAC_CODE));
endmodule // dac_fifo_waveform_sequencer_chk
bind dac_fifo_waveform_sequencer dac_fifo_waveform_sequencer_chk #(.DUAL_DAC(DUAL_DAC)) i_chk (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP),
	.PIN_LOAD_FIRST_DAC(PIN_LOAD_FIRST_DAC), .FIRST_DAC_CODE(FIRST_DAC_CODE),
	.SECOND_DAC_CODE(SECOND_DAC_CODE), .ANALOG_CTL(ANALOG_CTL));
`default_nettype wire

// >>> tb/dacseq_pin_src.sv
// model of the host pin that steps the waveform
`timescale 1ns/100ps
`default_nettype none
module dacseq_pin_src (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic go,
	output logic      pin
);
	logic [1:0] cnt_r;
	// three cycles high, long enough for the two-flop synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 2'd0;
		end else if (go) begin
			cnt_r <= 2'd3;
		end else if (cnt_r != 2'd0) begin
			cnt_r <= cnt_r - 2'd1;
		end
	end
	assign pin = cnt_r != 2'd0;
endmodule // dacseq_pin_src
`default_nettype wire

// >>> tb/dac_fifo_waveform_sequencer_tb.sv
// self-checking bench of the waveform sequencer
`timescale 1ns/100ps
`default_nettype none
`include "dacseq_params.svh"
module dac_fifo_waveform_sequencer_tb;
	import dacseq_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        go = 1'b0;
	logic        pin;
	wb_req_t     req = '0;
	wb_rsp_t     rsp;
	logic [11:0] code_a;
	logic [11:0] code_b;
	analog_ctl_t actl;
	logic [9:0]  got_ctl;
	int          fail_count = 0;
	int          num_checks = 0;
	int          seed = 55;
	logic [11:0] words [16];
	logic [11:0] seq_q [$];
	logic [31:0] q;
	////////////////////////////////////////////////////////////////////////
	dac_fifo_waveform_sequencer i_dac_fifo_waveform_sequencer (.CORE_CLK(clk), .SYS_RST(rst),
		.WB_REQ(req), .WB_RSP(rsp), .PIN_LOAD_FIRST_DAC(pin), .FIRST_DAC_CODE(code_a),
		.SECOND_DAC_CODE(code_b), .ANALOG_CTL(actl));
	dacseq_pin_src i_dacseq_pin_src (.clk(clk), .rst(rst), .go(go), .pin(pin));
	assign got_ctl = {actl.a_powered, actl.a_mode, actl.b_mode, actl.opamp_one_on,
		actl.ref_sel, actl.ref_buffer_on, actl.int_ref_on};
	initial begin
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; the bound stands in for a slave that never answers
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		req <= '{1'b1, 1'b1, w, a, 4'hf, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.ack !== 1'b1 && n < 40);
		q = rsp.dat;
		req <= '0;
		if (n >= 40) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	function automatic logic [11:0] comb(logic [11:0] b, logic [11:0] w, logic bip, logic sub);
		int v;
		v = bip ? (w[11] ? -int'(w[10:0]) : int'(w[10:0])) : int'(w);
		v = sub ? int'(b) - v : int'(b) + v;
		return v < 0 ? 12'h000 : (v > 4095 ? 12'hfff : 12'(v));
	endfunction
	function automatic logic [9:0] exp_ctl(logic [7:0] d);
		return {d[7:6] != 2'b00, d[7:4], d[3], d[2:1], d[2:1] != 2'b00, d[0]};
	endfunction
	// expected outputs of one pass, first entry the bare input value
	task automatic build(input logic [11:0] b, input logic bip, input logic sym, input int d);
		seq_q = {b};
		for (int i = 0; i < d; i++) begin
			seq_q.push_back(comb(b, words[i], bip, 1'b0));
		end
		for (int i = d - 1; i >= 0 && sym; i--) begin
			seq_q.push_back(comb(b, words[i], bip, 1'b0));
		end
		for (int i = 0; i < d && bip && sym; i++) begin
			seq_q.push_back(comb(b, words[i], bip, 1'b1));
		end
		for (int i = d - 1; i >= 0 && bip; i--) begin
			seq_q.push_back(comb(b, words[i], bip, 1'b1));
		end
	endtask
	// step by bus or by pin at random, then compare the code
	task automatic step(input int k, input logic con);
		int s;
		s = seq_q.size();
		if ($random(seed) & 1) begin
			wb(1'b1, `OFS_SEQ_STEP, 32'h0);
		end else begin
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (8) @(posedge clk);
		end
		@(posedge clk);
		chk(code_a, con ? seq_q[k % s] : seq_q[k < s ? k : s - 1]);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  d;
		logic [11:0] base;
		int          dep;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, `OFS_DAC_CTL, 32'h0);
		chk(q, {24'h0, `RST_DAC_CTL});
		wb(1'b0, `OFS_FIFO_CTL, 32'h0);
		chk(q, {24'h0, `RST_FIFO_CTL});
		chk(actl, '0);
		wb(1'b0, 8'h30, 32'h0);
		chk(q, 32'h0);
		// every power code first, then random control bytes
		for (int i = 0; i < 12; i++) begin
			d = (i < 4) ? {i[1:0], 6'h0} : 8'($random(seed));
			wb(1'b1, `OFS_DAC_CTL, {24'h0, d});
			wb(1'b0, `OFS_DAC_CTL, 32'h0);
			chk(q, {24'h0, d});
			chk(got_ctl, exp_ctl(d));
			chk({actl.a_drive, actl.b_powered, actl.b_drive},
				{d[7:6] != 2'b00, d[5:4] != 2'b00, d[5:4] != 2'b00});
		end
		wb(1'b1, `OFS_ADC_CTL, 32'h1);
		wb(1'b0, `OFS_DAC_CTL, 32'h0);
		chk(q[0], 1'b1);
		wb(1'b1, `OFS_DAC_CTL, 32'h40);
		wb(1'b0, `OFS_ADC_CTL, 32'h0);
		chk(q[0], 1'b0);
		// second channel: write both, input only, then shift
		wb(1'b1, `OFS_B_INPUT, 32'h111);
		chk(code_b, 12'h111);
		wb(1'b1, `OFS_DAC_CTL, 32'h60);
		wb(1'b1, `OFS_B_INPUT, 32'h5a5);
		chk(code_b, 12'h111);
		wb(1'b1, `OFS_DAC_CTL, 32'h70);
		wb(1'b1, `OFS_B_INPUT, 32'h3c3);
		chk(code_b, 12'h5a5);
		wb(1'b0, `OFS_B_INPUT, 32'h0);
		chk(q, 32'h3c3);
		// fill all sixteen words and one more that must be dropped
		wb(1'b1, `OFS_FIFO_CTL, 32'h0);
		for (int i = 0; i < 17; i++) begin
			if (i < 16) words[i] = 12'($random(seed));
			wb(1'b1, `OFS_FIFO_WORDS, {16'h0, (i < 16 ? words[i] : 12'hfff), 4'($random(seed))});
		end
		wb(1'b0, `OFS_FIFO_CTL, 32'h0);
		for (int i = 0; i < 17; i++) begin
			wb(1'b0, `OFS_FIFO_WORDS, 32'h0);
			chk(q[15:4], (i < 16 ? words[i] : 12'h000));
		end
		wb(1'b1, `OFS_FIFO_CTL, 32'h80);
		wb(1'b1, `OFS_FIFO_WORDS, {16'h0, ~words[0], 4'h0});
		wb(1'b0, `OFS_FIFO_CTL, 32'h0);
		wb(1'b0, `OFS_FIFO_WORDS, 32'h0);
		chk(q[15:4], words[0]);
		base = 12'h800;
		wb(1'b1, `OFS_A_INPUT, {20'h0, base});
		chk(code_a, base);
		// each phase layout, with the deepest setting last
		for (int c = 0; c < 4; c++) begin
			dep = (c == 3) ? 15 : ($random(seed) & 15);
			wb(1'b1, `OFS_FIFO_CTL, 32'h0);
			wb(1'b1, `OFS_FIFO_CTL, {24'h0, 1'b1, c[1], c[0], ~c[0], 4'(dep)});
			build(base, c[1], c[0], dep + 1);
			for (int k = 0; k < seq_q.size() + 3; k++) begin
				step(k, ~c[0]);
			end
		end
		// an output write while enabled moves the code, not the position
		wb(1'b1, `OFS_FIFO_CTL, 32'h93);
		build(base, 1'b0, 1'b0, 4);
		step(0, 1'b1);
		step(1, 1'b1);
		wb(1'b1, `OFS_A_OUTPUT, 32'h123);
		chk(code_a, 12'h123);
		wb(1'b0, `OFS_A_OUTPUT, 32'h0);
		chk(q, 32'h123);
		step(2, 1'b1);
		// reset in mid-run powers everything down again
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk(actl, '0);
		chk(code_a, 12'h000);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, `OFS_DAC_CTL, 32'h0);
		chk(q, {24'h0, `RST_DAC_CTL});
		report_and_stop();
	end
endmodule // dac_fifo_waveform_sequencer_tb
`default_nettype wire
